// ===== rtl/ppm_defines.vh
`ifndef PPM_DEFINES_VH
`define PPM_DEFINES_VH
// ==========================================
// Register indices (byte address = 4 * index)
`define PPM_IDX_EVLUT      8'h00
`define PPM_IDX_SERIAL     8'h01
`define PPM_IDX_TMRA       8'h02
`define PPM_IDX_TMRB       8'h03
// ==========================================
// Writable bit masks
`define PPM_MASK_EVLUT     8'h37
`define PPM_MASK_SERIAL    8'h15
`define PPM_MASK_TMRA      8'h3F
`define PPM_MASK_TMRB      8'h01
// ==========================================
// Field positions
`define PPM_BIT_LOOKUP_ONE  5
`define PPM_BIT_LOOKUP_ZERO 4
`define PPM_BIT_EV2        2
`define PPM_BIT_EV1        1
`define PPM_BIT_EV0        0
`define PPM_BIT_TWI        4
`define PPM_BIT_SPI        2
`define PPM_BIT_UART       0
`define PPM_BIT_TMRB       0
// ==========================================
// Reset value
`define PPM_RST_VAL        8'h00
`endif

// ===== rtl/ppm_reg8.v
`timescale 1ns/100ps
// ==========================================
// Masked byte register
module ppm_reg8 #(
  parameter [7:0] MASK = 8'hFF
) (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       wr_en,
  input  wire [7:0] wdata,
  output reg  [7:0] q_r
);
`include "ppm_defines.vh"
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= `PPM_RST_VAL;
    end else if (wr_en) begin
      q_r <= wdata & MASK;
    end
  end
endmodule // ppm_reg8

// ===== rtl/ppm_route.v
`timescale 1ns/100ps
// ==========================================
// One signal to default or alternative pad
module ppm_route (
  input  wire sel_alt,
  input  wire sig_in,
  output wire pad_dflt,
  output wire pad_alt
);
  assign pad_dflt = sig_in & ~sel_alt;
  assign pad_alt  = sig_in &  sel_alt;
endmodule // ppm_route

// ===== rtl/ppm_top.v
// Register access over APB was decided locally.
`timescale 1ns/100ps
module ppm_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [1:0]  lut_out,
  output wire [1:0]  lut_pad_dflt,
  output wire [1:0]  lut_pad_alt,
  input  wire [2:0]  event_out,
  output wire [2:0]  event_pad,
  input  wire        timer_a_split,
  input  wire [5:0]  timer_a_wave,
  output wire [5:0]  timer_a_pad_dflt,
  output wire [5:0]  timer_a_pad_alt,
  input  wire        timer_b_out,
  output wire        timer_b_pad_dflt,
  output wire        timer_b_pad_alt,
  output wire        two_wire_alt_pads,
  output wire        serial_periph_alt_pads,
  output wire        async_serial_alt_pads
);
`include "ppm_defines.vh"
  // ==========================================
  // APB decode
  wire       acc      = psel & penable;
  wire       wr       = acc & pwrite;
  wire [9:0] idx      = paddr[11:2];
  wire       hit      = (idx[9:2] == 8'h00) & (paddr[1:0] == 2'b00);
  wire [7:0] sub      = {6'h00, idx[1:0]};
  wire       wr_evlut = wr & hit & (sub == `PPM_IDX_EVLUT);
  wire       wr_ser   = wr & hit & (sub == `PPM_IDX_SERIAL);
  wire       wr_tmra  = wr & hit & (sub == `PPM_IDX_TMRA);
  wire       wr_tmrb  = wr & hit & (sub == `PPM_IDX_TMRB);
  wire [7:0] event_and_lut_routing;
  wire [7:0] serial_pin_routing;
  wire [7:0] timer_a_output_routing;
  wire [7:0] timer_b_output_routing;
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;
  // ==========================================
  // Control registers
  ppm_reg8 #(.MASK(`PPM_MASK_EVLUT)) u_evlut (
    .pclk(pclk), .presetn(presetn), .wr_en(wr_evlut), .wdata(pwdata[7:0]), .q_r(event_and_lut_routing));
  ppm_reg8 #(.MASK(`PPM_MASK_SERIAL)) u_ser (
    .pclk(pclk), .presetn(presetn), .wr_en(wr_ser), .wdata(pwdata[7:0]), .q_r(serial_pin_routing));
  ppm_reg8 #(.MASK(`PPM_MASK_TMRA)) u_tmra (
    .pclk(pclk), .presetn(presetn), .wr_en(wr_tmra), .wdata(pwdata[7:0]), .q_r(timer_a_output_routing));
  ppm_reg8 #(.MASK(`PPM_MASK_TMRB)) u_tmrb (
    .pclk(pclk), .presetn(presetn), .wr_en(wr_tmrb), .wdata(pwdata[7:0]), .q_r(timer_b_output_routing));
  // ==========================================
  // Read data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      case (hit ? idx : 10'h3FF)
        10'h000: prdata <= {24'h00_0000, event_and_lut_routing};
        10'h001: prdata <= {24'h00_0000, serial_pin_routing};
        10'h002: prdata <= {24'h00_0000, timer_a_output_routing};
        10'h003: prdata <= {24'h00_0000, timer_b_output_routing};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
  // ==========================================
  // Routing
  wire lookup_one_alt_pad  = event_and_lut_routing[`PPM_BIT_LOOKUP_ONE];
  wire lookup_zero_alt_pad = event_and_lut_routing[`PPM_BIT_LOOKUP_ZERO];
  wire [5:0] wave_sel = {timer_a_output_routing[5:3] & {3{timer_a_split}},
                         timer_a_output_routing[2:0]};
  ppm_route u_lookup_one (.sel_alt(lookup_one_alt_pad), .sig_in(lut_out[1]),
    .pad_dflt(lut_pad_dflt[1]), .pad_alt(lut_pad_alt[1]));
  ppm_route u_lookup_zero (.sel_alt(lookup_zero_alt_pad), .sig_in(lut_out[0]),
    .pad_dflt(lut_pad_dflt[0]), .pad_alt(lut_pad_alt[0]));
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_wave
      ppm_route u_w (.sel_alt(wave_sel[g]), .sig_in(timer_a_wave[g]),
        .pad_dflt(timer_a_pad_dflt[g]), .pad_alt(timer_a_pad_alt[g]));
    end
  endgenerate
  ppm_route u_tb (.sel_alt(timer_b_output_routing[`PPM_BIT_TMRB]), .sig_in(timer_b_out),
    .pad_dflt(timer_b_pad_dflt), .pad_alt(timer_b_pad_alt));
  assign event_pad[2] = event_out[2] & event_and_lut_routing[`PPM_BIT_EV2];
  assign event_pad[1] = event_out[1] & event_and_lut_routing[`PPM_BIT_EV1];
  assign event_pad[0] = event_out[0] & event_and_lut_routing[`PPM_BIT_EV0];
  assign two_wire_alt_pads      = serial_pin_routing[`PPM_BIT_TWI];
  assign serial_periph_alt_pads = serial_pin_routing[`PPM_BIT_SPI];
  assign async_serial_alt_pads  = serial_pin_routing[`PPM_BIT_UART];
endmodule // ppm_top

// ===== tb/ppm_periph.sv
`timescale 1ns/100ps
// ==========================================
// Peripheral side: random signals per cycle
module ppm_periph (
  input  logic       pclk,
  output logic [1:0] lut_out,
  output logic [2:0] event_out,
  output logic       split,
  output logic [5:0] wave,
  output logic       tb_out
);
  initial {lut_out, event_out, split, wave, tb_out} = 13'h0000;
  always @(posedge pclk) begin
    {lut_out, event_out, split, wave, tb_out} <= 13'($urandom);
  end
endmodule // ppm_periph

// ===== tb/ppm_top_assertions.sv
`timescale 1ns/100ps
// ==========================================
// Port checker
module ppm_checker (
  input logic        pclk, presetn, psel, penable, pwrite, pslverr, timer_a_split, timer_b_out,
  input logic        timer_b_pad_dflt, timer_b_pad_alt, two_wire_alt_pads, serial_periph_alt_pads,
  input logic        async_serial_alt_pads,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic [1:0]  lut_out, lut_pad_dflt, lut_pad_alt,
  input logic [2:0]  event_out, event_pad,
  input logic [5:0]  timer_a_wave, timer_a_pad_dflt, timer_a_pad_alt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd; psel && !penable && !pwrite; endsequence
  property p_lut; ((lut_pad_alt & lut_pad_dflt) == 2'h0) && ((lut_pad_alt | lut_pad_dflt) == lut_out); endproperty
  a_lut: assert property (p_lut) else $error("lut routing wrong");
  property p_ev; (event_pad & ~event_out) == 3'h0; endproperty
  a_ev: assert property (p_ev) else $error("event pad without source");
  property p_tb; !(timer_b_pad_alt && timer_b_pad_dflt) && ((timer_b_pad_alt | timer_b_pad_dflt) == timer_b_out); endproperty
  a_tb: assert property (p_tb) else $error("timer b routing wrong");
  property p_split; !timer_a_split |-> timer_a_pad_alt[5:3] == 3'h0; endproperty
  a_split: assert property (p_split) else $error("upper waves moved in normal mode");
  property p_ta; ((timer_a_pad_alt & timer_a_pad_dflt) == 6'h00) && ((timer_a_pad_alt | timer_a_pad_dflt) == timer_a_wave);
  endproperty
  a_ta: assert property (p_ta) else $error("timer a wave lost");
  property p_ser; !(psel && penable && pwrite && paddr == 12'h004) |=>
    $stable({two_wire_alt_pads, serial_periph_alt_pads, async_serial_alt_pads}); endproperty
  a_ser: assert property (p_ser) else $error("serial routing changed without write");
  property p_rd; s_rd ##1 (psel && penable) |-> prdata[31:8] == 24'h00_0000; endproperty
  a_rd: assert property (p_rd) else $error("upper read bits set");
  property p_err; psel && penable && paddr[1:0] != 2'h0 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unaligned access not flagged");
endmodule // ppm_checker
bind ppm_top ppm_checker u_ppm_checker (.*);

// ===== tb/test_peripheral_pin_multiplexer.sv
`timescale 1ns/100ps
`include "ppm_defines.vh"
module test_peripheral_pin_multiplexer;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, split, tbo, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [1:0] lut, lpa;
  logic [2:0] ev, evp;
  logic [5:0] wv, wpa;
  logic tpa, s2, s1, s0;
  int n_errors = 0, check_count = 0;
  always #20 pclk = ~pclk;
  ppm_periph u_ppm_periph (.pclk(pclk), .lut_out(lut), .event_out(ev), .split(split), .wave(wv), .tb_out(tbo));
  ppm_top u_ppm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lut_out(lut),
    .lut_pad_dflt(), .lut_pad_alt(lpa), .event_out(ev), .event_pad(evp), .timer_a_split(split),
    .timer_a_wave(wv), .timer_a_pad_dflt(), .timer_a_pad_alt(wpa), .timer_b_out(tbo), .timer_b_pad_dflt(),
    .timer_b_pad_alt(tpa), .two_wire_alt_pads(s2), .serial_periph_alt_pads(s1), .async_serial_alt_pads(s0));
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h00_0000, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin n_errors++; $display("ERROR %s expected %h seen %h", n, e, g); end
  endtask
  function automatic logic [14:0] exp_pads(input logic [7:0] a, b, c, d);
    return {lut & a[5:4], ev & a[2:0], wv & c[5:0] & {{3{split}}, 3'h7}, tbo & d[0], b[4], b[2], b[0]};
  endfunction
  task final_report;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin #100000; n_errors++; final_report; end
  initial begin
    logic [31:0] r; logic [7:0] d; logic [7:0] sh [4]; logic [7:0] m [4]; int i;
    m = '{`PPM_MASK_EVLUT, `PPM_MASK_SERIAL, `PPM_MASK_TMRA, `PPM_MASK_TMRB};
    sh = '{8'h00, 8'h00, 8'h00, 8'h00};
    void'($urandom(32'hfa81));
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (i = 0; i < 4; i++) begin apb(0, 12'(i * 4), 8'h00, r); chk("reset", 0, r); end
    $display("test reset done");
    for (int k = 0; k < 48; k++) begin
      i = k % 4;
      d = k < 4 ? 8'hff : k >= 44 ? 8'h00 : 8'($urandom);
      apb(1, 12'(i * 4), d, r);
      sh[i] = d & m[i];
      apb(0, 12'(i * 4), 8'h00, r); chk("readback", {24'h00_0000, sh[i]}, r);
      @(negedge pclk) chk("pads", exp_pads(sh[0], sh[1], sh[2], sh[3]), {lpa, evp, wpa, tpa, s2, s1, s0});
      @(posedge pclk);
    end
    $display("test routing done");
    apb(0, 12'h010, 8'h00, r); chk("unmapped", 0, r);
    chk("slverr", 1, {31'h0, err});
    apb(1, 12'h005, 8'hff, r);
    chk("unaligned_wr_err", 1, {31'h0, err});
    apb(0, 12'h004, 8'h00, r); chk("unaligned_wr_ignored", 0, r);
    apb(0, 12'h005, 8'h00, r); chk("unaligned_rd", 0, r);
    chk("unaligned_rd_err", 1, {31'h0, err});
    $display("test unmapped done");
    final_report;
  end
endmodule // test_peripheral_pin_multiplexer
